// ---- hdl/ari_pkg.sv ----
// Package: constants, types and register map of the start interlock and aux relays
//------------------------------------------------------------------------------
// Overview of operation
// - Selector offers disabled, damper or lubrication.
// - Damper: close relay, start after timer.
// - Interlock timer resets to 30 seconds.
// - Damper switch assigned: start on switch closed.
// - Switch still open at expiry: damper fault trip.
// - Sequence repeats on every start command.
// - Lube: relay closed for timer, then start.
// - Four independent selectors; none holds open.
// - Mode 1: ramping, reference error under half-band.
// - Mode 2: ramping, both inside detect band.
// - Mode 3: output inside detect band.
// - Mode 4: close at detect, open below hysteresis.
// - Mode 5 inverts mode 4.
// - Overload warning after level held warning time.
// - Drive overload above 110% for 60 s.
// - Stall relay closed during stall prevention.
// - Overvoltage limit by class 410/820/1025 V.
// - Undervoltage 200 V or 400 V by line.
// - Overheat on module or motor sensor.
// - Lost reference closes relay.
// - Run closes with output, stop without.
// - Full-scale input at raw code 4095.
// - Damper relay held until stop or fault trip.
// - Refill keeps relay one more timer span.
//------------------------------------------------------------------------------
package ari_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_FDT = 8'h04;
  localparam logic [7:0] OFS_AUXSEL = 8'h08;
  localparam logic [7:0] OFS_OLCFG = 8'h0C;
  localparam logic [7:0] OFS_DRVCFG = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;

  // Values after reset
  localparam logic [15:0] RST_ITIME = 16'h001E;
  localparam logic [15:0] RST_FDT_FREQ = 16'h0064;
  localparam logic [15:0] RST_FDT_BAND = 16'h0064;
  localparam logic [15:0] RST_OL_LEVEL = 16'h0096;
  localparam logic [15:0] RST_OL_TIME = 16'h000A;
  localparam logic [7:0] RST_IOL_PCT = 8'h6E;
  localparam logic [15:0] IOL_TIME = 16'h003C;

  // Voltage limits
  localparam logic [11:0] OV_230 = 12'h19A;
  localparam logic [11:0] OV_480 = 12'h334;
  localparam logic [11:0] OV_600 = 12'h401;
  localparam logic [11:0] UV_240 = 12'h0C8;
  localparam logic [11:0] UV_480 = 12'h190;
  localparam logic [11:0] ADC_FULL = 12'hFFF;

  // Control tick timing
  localparam int CLK_NS = 10;
  localparam int TICK_NS = 1000000;
  localparam int TICK_CYCLES_DEF = (TICK_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [9:0] SEC_TICKS = 10'h3E8;

  typedef enum logic [1:0] {
    IL_NONE = 2'h0,
    IL_DAMPER = 2'h1,
    IL_LUBE = 2'h2
  } ari_ilmode_type;

  typedef enum logic [4:0] {
    SEQ_IDLE = 5'h01,
    SEQ_DELAY = 5'h02,
    SEQ_RUN = 5'h04,
    SEQ_REFILL = 5'h08,
    SEQ_FAULT = 5'h10
  } ari_seq_type;

  // Relay function codes
  typedef enum logic [4:0] {
    FN_NONE = 5'h00, FN_FDT1 = 5'h01, FN_FDT2 = 5'h02, FN_FDT3 = 5'h03,
    FN_FDT4 = 5'h04, FN_FDT5 = 5'h05, FN_OLW = 5'h06, FN_DOL = 5'h07,
    FN_STALL = 5'h08, FN_OV = 5'h09, FN_UV = 5'h0A, FN_OH = 5'h0B,
    FN_LOST = 5'h0C, FN_RUN = 5'h0D, FN_STOP = 5'h0E, FN_DAMPER = 5'h0F,
    FN_LUBE = 5'h10, FN_REFILL = 5'h11, FN_VFULL = 5'h12, FN_IFULL = 5'h13
  } ari_func_type;

  localparam int NFUNC = 20;
  typedef logic [NFUNC-1:0] ari_cond_type;

  typedef struct packed {
    logic [15:0] out_freq;
    logic [15:0] speed_ref;
    logic ramping;
    logic [15:0] out_current;
    logic stall;
    logic [11:0] bus_volts;
    logic module_hot;
    logic motor_hot;
    logic ref_lost;
    logic [11:0] adc_v;
    logic [11:0] adc_i;
  } ari_drive_type;

endpackage

// ---- hdl/ari_persist.sv ----
// Module: condition held for a number of seconds
`timescale 1ns/10ps
module ari_persist
  import ari_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire logic tick,
  input wire logic sec,
  input wire logic cond,
  input wire logic [15:0] limit,
  output logic hit
);
  typedef struct packed {
    logic [15:0] cnt;
    logic hit;
  } ari_pst_type;

  ari_pst_type q, d;

  always_comb begin
    d = q;
    if (tick) begin
      if (!cond) begin
        d.cnt = 16'h0000;
        d.hit = 1'b0;
      end else begin
        if (sec && q.cnt != 16'hFFFF) begin
          d.cnt = q.cnt + 16'h0001;
        end
        d.hit = (q.cnt >= limit);
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign hit = q.hit;
endmodule

// ---- hdl/ari_relay_sel.sv ----
// Module: one auxiliary relay with its function selector
`timescale 1ns/10ps
module ari_relay_sel
  import ari_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire logic tick,
  input wire logic [4:0] sel,
  input wire ari_cond_type cond,
  output logic relay
);
  logic relay_q, relay_d;

  always_comb begin
    relay_d = relay_q;
    if (tick) begin
      if (sel == FN_NONE || int'(sel) >= NFUNC) begin
        relay_d = 1'b0;
      end else begin
        relay_d = cond[sel];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      relay_q <= 1'b0;
    end else begin
      relay_q <= relay_d;
    end
  end

  assign relay = relay_q;
endmodule

// ---- hdl/ari_start_interlock.sv ----
// Module: start interlock sequencer, relay functions and APB register file
//
// Design decisions made here: the APB register port and the register addresses.
`timescale 1ns/10ps
module ari_start_interlock
  import ari_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF,
  parameter logic [15:0] RATED_CURRENT = 16'h0064
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic run_cmd,
  input wire logic damper_sw_assigned,
  input wire logic damper_sw_closed,
  input wire ari_drive_type drive,
  output logic [3:0] aux_relay,
  output logic motor_start,
  output logic damper_fault
);

  //----------------------------------------------------------------------------
  // State
  //----------------------------------------------------------------------------
  typedef struct packed {
    logic [16:0] pre;
    logic [9:0] tms;
    logic tick;
    logic sec;
    logic [1:0] mode;
    logic [15:0] itime;
    logic [15:0] fdt_freq;
    logic [15:0] fdt_band;
    logic [3:0][4:0] sel;
    logic [15:0] ol_level;
    logic [15:0] ol_time;
    logic [7:0] iol_pct;
    logic [1:0] dclass;
    logic line480;
    logic [4:0] seq;
    logic [15:0] dly;
    logic run_prev;
    logic fdt4;
    logic motor_start;
    logic damper_fault;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } ari_top_type;

  ari_top_type q, d;
  ari_cond_type cond;
  logic olw_hit;
  logic dol_hit;
  logic [16:0] f_out2;
  logic [16:0] f_det2;
  logic [16:0] f_ref2;
  logic [16:0] err_ref;
  logic [16:0] err_out;
  logic [16:0] err_rdet;
  logic [16:0] half_low;
  logic [23:0] cur_scaled;
  logic [23:0] iol_limit;
  logic [11:0] ov_limit;
  logic wr_en;
  logic setup;

  //----------------------------------------------------------------------------
  // Frequency arithmetic, doubled so half-band needs no division
  //----------------------------------------------------------------------------
  always_comb begin
    f_out2 = {drive.out_freq, 1'b0};
    f_det2 = {q.fdt_freq, 1'b0};
    f_ref2 = {drive.speed_ref, 1'b0};
    err_ref = (drive.speed_ref > drive.out_freq) ?
              17'(drive.speed_ref - drive.out_freq) : 17'(drive.out_freq - drive.speed_ref);
    err_out = (f_out2 > f_det2) ? (f_out2 - f_det2) : (f_det2 - f_out2);
    err_rdet = (f_ref2 > f_det2) ? (f_ref2 - f_det2) : (f_det2 - f_ref2);
    half_low = (f_det2 > {1'b0, q.fdt_band}) ? (f_det2 - {1'b0, q.fdt_band}) : 17'h00000;
    cur_scaled = 24'(drive.out_current) * 24'h000064;
    iol_limit = 24'(RATED_CURRENT) * 24'(q.iol_pct);
    case (q.dclass)
      2'h0: ov_limit = OV_230;
      2'h1: ov_limit = OV_480;
      default: ov_limit = OV_600;
    endcase
  end

  //----------------------------------------------------------------------------
  // Relay function conditions
  //----------------------------------------------------------------------------
  always_comb begin
    cond = '0;
    cond[FN_FDT1] = drive.ramping && ({err_ref[15:0], 1'b0} < q.fdt_band + 17'h00000);
    cond[FN_FDT2] = drive.ramping && (err_out <= {1'b0, q.fdt_band})
                    && (err_rdet <= {1'b0, q.fdt_band});
    cond[FN_FDT3] = (err_out <= {1'b0, q.fdt_band});
    cond[FN_FDT4] = q.fdt4;
    cond[FN_FDT5] = !q.fdt4;
    cond[FN_OLW] = olw_hit;
    cond[FN_DOL] = dol_hit;
    cond[FN_STALL] = drive.stall;
    cond[FN_OV] = (drive.bus_volts > ov_limit);
    cond[FN_UV] = (drive.bus_volts < (q.line480 ? UV_480 : UV_240));
    cond[FN_OH] = drive.module_hot || drive.motor_hot;
    cond[FN_LOST] = drive.ref_lost;
    cond[FN_RUN] = (drive.out_freq != 16'h0000);
    cond[FN_STOP] = (drive.out_freq == 16'h0000);
    cond[FN_DAMPER] = (q.mode == IL_DAMPER)
                      && (q.seq == SEQ_DELAY || q.seq == SEQ_RUN);
    cond[FN_LUBE] = (q.mode == IL_LUBE) && (q.seq == SEQ_DELAY);
    cond[FN_REFILL] = (q.mode == IL_LUBE)
                      && (q.seq == SEQ_DELAY || q.seq == SEQ_REFILL);
    cond[FN_VFULL] = (drive.adc_v == ADC_FULL);
    cond[FN_IFULL] = (drive.adc_i == ADC_FULL);
  end

  ari_persist u_olw (
    .clock(clock),
    .srst(srst),
    .tick(q.tick),
    .sec(q.sec),
    .cond(drive.out_current > q.ol_level),
    .limit(q.ol_time),
    .hit(olw_hit)
  );

  ari_persist u_dol (
    .clock(clock),
    .srst(srst),
    .tick(q.tick),
    .sec(q.sec),
    .cond(cur_scaled > iol_limit),
    .limit(IOL_TIME),
    .hit(dol_hit)
  );

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_relay
      ari_relay_sel u_sel (
        .clock(clock),
        .srst(srst),
        .tick(q.tick),
        .sel(q.sel[gi]),
        .cond(cond),
        .relay(aux_relay[gi])
      );
    end
  endgenerate

  //----------------------------------------------------------------------------
  // Next state
  //----------------------------------------------------------------------------
  assign setup = psel && !penable;
  assign wr_en = psel && penable && pwrite && q.pready;

  always_comb begin
    d = q;
    // Control tick and one-second strobe
    d.tick = 1'b0;
    d.sec = 1'b0;
    if (q.pre >= 17'(TICK_CYCLES - 1)) begin
      d.pre = 17'h00000;
      d.tick = 1'b1;
      if (q.tms >= SEC_TICKS - 10'h001) begin
        d.tms = 10'h000;
        d.sec = 1'b1;
      end else begin
        d.tms = q.tms + 10'h001;
      end
    end else begin
      d.pre = q.pre + 17'h00001;
    end

    if (q.tick) begin
      d.run_prev = run_cmd;
      // Detect-frequency hysteresis shared by modes 4 and 5
      if (f_out2 < half_low || drive.out_freq == 16'h0000) begin
        d.fdt4 = 1'b0;
      end else if (drive.out_freq >= q.fdt_freq) begin
        d.fdt4 = 1'b1;
      end
      if (q.sec && q.dly != 16'hFFFF) begin
        d.dly = q.dly + 16'h0001;
      end
      case (q.seq)
        SEQ_IDLE: begin
          if (run_cmd && !q.run_prev) begin
            d.dly = 16'h0000;
            if (q.mode == IL_NONE || q.mode == 2'h3) begin
              d.seq = SEQ_RUN;
            end else begin
              d.seq = SEQ_DELAY;
            end
          end
        end
        SEQ_DELAY: begin
          if (!run_cmd) begin
            d.seq = SEQ_IDLE;
          end else if (q.mode == IL_DAMPER && damper_sw_assigned) begin
            if (damper_sw_closed) begin
              d.seq = SEQ_RUN;
            end else if (q.dly >= q.itime) begin
              d.seq = SEQ_FAULT;
            end
          end else if (q.dly >= q.itime) begin
            d.dly = 16'h0000;
            d.seq = (q.mode == IL_LUBE) ? SEQ_REFILL : SEQ_RUN;
          end
        end
        SEQ_REFILL: begin
          if (!run_cmd) begin
            d.seq = SEQ_IDLE;
          end else if (q.dly >= q.itime) begin
            d.seq = SEQ_RUN;
          end
        end
        SEQ_RUN, SEQ_FAULT: begin
          if (!run_cmd) begin
            d.seq = SEQ_IDLE;
          end
        end
        default: d.seq = SEQ_IDLE;
      endcase
      d.motor_start = (d.seq == SEQ_RUN || d.seq == SEQ_REFILL);
      d.damper_fault = (d.seq == SEQ_FAULT);
    end

    // APB: answer prepared in the setup cycle, ready in the access cycle
    d.pready = setup;
    if (setup) begin
      d.pslverr = 1'b0;
      d.prdata = 32'h00000000;
      case (paddr)
        OFS_CTRL: d.prdata = {14'h0000, q.mode, q.itime};
        OFS_FDT: d.prdata = {q.fdt_band, q.fdt_freq};
        OFS_AUXSEL: d.prdata = {3'h0, q.sel[3], 3'h0, q.sel[2], 3'h0, q.sel[1], 3'h0, q.sel[0]};
        OFS_OLCFG: d.prdata = {q.ol_time, q.ol_level};
        OFS_DRVCFG: d.prdata = {21'h000000, q.line480, q.dclass, q.iol_pct};
        OFS_STATUS: d.prdata = {20'h00000, q.damper_fault, q.motor_start, q.fdt4,
                                q.seq, aux_relay};
        default: d.pslverr = 1'b1;
      endcase
    end else begin
      d.pslverr = 1'b0;
    end

    if (wr_en) begin
      case (paddr)
        OFS_CTRL: begin
          d.mode = pwdata[17:16];
          d.itime = pwdata[15:0];
        end
        OFS_FDT: begin
          d.fdt_freq = pwdata[15:0];
          d.fdt_band = pwdata[31:16];
        end
        OFS_AUXSEL: begin
          d.sel[0] = pwdata[4:0];
          d.sel[1] = pwdata[12:8];
          d.sel[2] = pwdata[20:16];
          d.sel[3] = pwdata[28:24];
        end
        OFS_OLCFG: begin
          d.ol_level = pwdata[15:0];
          d.ol_time = pwdata[31:16];
        end
        OFS_DRVCFG: begin
          d.iol_pct = pwdata[7:0];
          d.dclass = pwdata[9:8];
          d.line480 = pwdata[10];
        end
        default: d.mode = q.mode;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      q <= '0;
      q.seq <= SEQ_IDLE;
      q.itime <= RST_ITIME;
      q.fdt_freq <= RST_FDT_FREQ;
      q.fdt_band <= RST_FDT_BAND;
      q.ol_level <= RST_OL_LEVEL;
      q.ol_time <= RST_OL_TIME;
      q.iol_pct <= RST_IOL_PCT;
    end else begin
      q <= d;
    end
  end

  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign motor_start = q.motor_start;
  assign damper_fault = q.damper_fault;
endmodule

// ---- sim/ari_start_interlock_asserts.sv ----
// Checker: port timing of the start interlock, relays and register bus
`timescale 1ns/10ps
module ari_start_interlock_asserts
  import ari_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic run_cmd,
  input wire logic [3:0] aux_relay,
  input wire logic motor_start,
  input wire logic damper_fault
);
  localparam int STOP_LAT = 3 * TICK_CYCLES + 2;
  logic [31:0] gap_q;
  logic [31:0] low_q;
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  //---
  // Cycles since outputs last moved, and since run command went low
  //---
  always_ff @(posedge clock) begin
    if (srst) begin
      gap_q <= 32'hFFFFFFFF;
    end else if ($changed({aux_relay, motor_start, damper_fault})) begin
      gap_q <= 32'h00000000;
    end else if (gap_q != 32'hFFFFFFFF) begin
      gap_q <= gap_q + 32'h00000001;
    end
  end
  always_ff @(posedge clock) begin
    if (srst || run_cmd) begin
      low_q <= 32'h00000000;
    end else if (low_q != 32'hFFFFFFFF) begin
      low_q <= low_q + 32'h00000001;
    end
  end
  tick_spacing_a: assert property (
    $changed({aux_relay, motor_start, damper_fault}) |-> gap_q >= TICK_CYCLES - 1)
    else $error("outputs moved between control ticks");
  ready_pulse_a: assert property (
    psel && !penable |=> pready ##1 !pready)
    else $error("pready not a one cycle answer");
  err_ready_a: assert property (
    pslverr |-> pready)
    else $error("pslverr without pready");
  refused_read_a: assert property (
    pready && pslverr && !pwrite |-> prdata == 32'h00000000)
    else $error("refused read returned data");
  start_cmd_a: assert property (
    $rose(motor_start) |-> low_q <= TICK_CYCLES)
    else $error("motor start without start command");
  fault_blocks_a: assert property (
    damper_fault |-> !motor_start)
    else $error("motor started while damper fault");
  stop_only_a: assert property (
    $fell(motor_start) || $fell(damper_fault) |-> low_q != 32'h00000000)
    else $error("start or fault dropped while running");
  stop_release_a: assert property (
    low_q > STOP_LAT |-> !motor_start && !damper_fault)
    else $error("start or fault held after stop");
endmodule

bind ari_start_interlock ari_start_interlock_asserts #(.TICK_CYCLES(TICK_CYCLES)) chk (
  .clock, .srst, .psel, .penable, .pwrite, .prdata, .pready, .pslverr,
  .run_cmd, .aux_relay, .motor_start, .damper_fault);

// ---- sim/ari_damper_model.sv ----
// Partner: damper actuator whose limit switch closes after travel
`timescale 1ns/10ps
module ari_damper_model (
  input wire logic clock,
  input wire logic relay,
  input wire logic stuck,
  output logic sw_closed
);
  logic [7:0] travel_q;
  // A stuck damper never reports closed
  always_ff @(posedge clock) begin
    if (!relay) begin
      travel_q <= 8'h00;
      sw_closed <= 1'b0;
    end else if (travel_q != 8'hC8) begin
      travel_q <= travel_q + 8'h01;
    end else begin
      sw_closed <= !stuck;
    end
  end
endmodule

// ---- sim/testbench.sv ----
// Testbench: registers, interlock sequences and relay functions
`timescale 1ns/10ps
module testbench;
  import ari_pkg::*;
  localparam int TC = 4;
  localparam int SEC = 4000;
  localparam logic [23:0] FN_EXP = 24'h042B1E;
  logic clock, srst, psel, penable, pwrite, pready, pslverr, err;
  logic run_cmd, sw_asg, sw_closed, stuck, motor_start, damper_fault;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] aux_relay;
  ari_drive_type drive;
  int mismatches, cmp_count, n;

  ari_start_interlock #(.TICK_CYCLES(TC)) dut (
    .clock, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .run_cmd, .damper_sw_assigned(sw_asg), .damper_sw_closed(sw_closed), .drive,
    .aux_relay, .motor_start, .damper_fault);
  ari_damper_model damper (.clock, .relay(aux_relay[0]), .stuck, .sw_closed);

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  //---
  // Tasks
  //---
  task automatic finish_test();
    $display("Comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clock);
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clock);
      i++;
    end while (pready !== 1'b1 && i < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i >= 20) begin
      chk("pready", 32'h1, 32'h0);
      finish_test();
    end
  endtask
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h00000000);
    chk(what, exp, rd);
  endtask
  task automatic wait_out(input logic fault, input int max);
    n = 0;
    while ((fault ? damper_fault : motor_start) !== 1'b1) begin
      @(posedge clock);
      n++;
      if (n > max) begin
        chk(fault ? "fault wait" : "start wait", 32'h1, 32'h0);
        finish_test();
      end
    end
  endtask
  task automatic fstep(input logic [15:0] f, input logic [11:0] v, input logic [31:0] cfg,
                       input logic [3:0] exp);
    apb(1'b1, OFS_DRVCFG, cfg);
    drive.out_freq <= f;
    drive.bus_volts <= v;
    cyc(4 * TC);
    chk("detect and voltage", 32'(exp), 32'(aux_relay));
  endtask
  task automatic run(input logic on);
    run_cmd <= on;
    cyc(4 * TC);
  endtask
  //---
  // Sequence
  //---
  initial begin
    mismatches = 0;
    cmp_count = 0;
    srst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    run_cmd = 1'b0;
    sw_asg = 1'b0;
    stuck = 1'b0;
    drive = '{16'h0078, 16'h0082, 1'b1, 16'h0000, 1'b1, 12'h1A0, 1'b1, 1'b0, 1'b0, 12'hFFF,
              12'h000};
    cyc(12);
    srst <= 1'b0;
    rd_chk("ctrl", OFS_CTRL, 32'h0000001E);
    rd_chk("fdt", OFS_FDT, 32'h00640064);
    rd_chk("auxsel", OFS_AUXSEL, 32'h00000000);
    rd_chk("olcfg", OFS_OLCFG, 32'h000A0096);
    rd_chk("drvcfg", OFS_DRVCFG, 32'h0000006E);
    apb(1'b1, OFS_STATUS, 32'hFFFFFFFF);
    rd_chk("status", OFS_STATUS, 32'h00000210);
    rd_chk("unmapped", 8'h18, 32'h00000000);
    chk("slverr", 32'h1, 32'(err));
    for (int g = 0; g < 6; g++) begin
      apb(1'b1, OFS_AUXSEL, {3'h0, 5'(4*g+3), 3'h0, 5'(4*g+2), 3'h0, 5'(4*g+1), 3'h0, 5'(4*g)});
      cyc(4 * TC);
      chk("functions", 32'(FN_EXP[4*g +: 4]), 32'(aux_relay));
    end
    apb(1'b1, OFS_AUXSEL, 32'h0A090504);
    fstep(16'h003C, 12'h1A0, 32'h0000006E, 4'h5);
    fstep(16'h0028, 12'h0C0, 32'h0000006E, 4'hA);
    fstep(16'h003C, 12'h1A0, 32'h0000016E, 4'h2);
    fstep(16'h0000, 12'h180, 32'h0000056E, 4'hA);
    drive.module_hot <= 1'b0;
    drive.motor_hot <= 1'b1;
    drive.ref_lost <= 1'b1;
    drive.adc_i <= 12'hFFF;
    apb(1'b1, OFS_AUXSEL, 32'h0E130C0B);
    fstep(16'h0000, 12'h180, 32'h0000056E, 4'hF);
    drive.ramping <= 1'b0;
    drive.adc_v <= 12'h000;
    apb(1'b1, OFS_AUXSEL, 32'h120D0201);
    fstep(16'h0000, 12'h180, 32'h0000056E, 4'h0);
    apb(1'b1, OFS_OLCFG, 32'h00010096);
    apb(1'b1, OFS_AUXSEL, 32'h00000006);
    drive.out_current <= 16'h00C8;
    cyc(2 * SEC + 8 * TC);
    chk("overload warn", 32'h1, 32'(aux_relay));
    drive.out_current <= 16'h0000;
    cyc(4 * TC);
    chk("overload clear", 32'h0, 32'(aux_relay));
    apb(1'b1, OFS_CTRL, 32'h00000002);
    apb(1'b1, OFS_AUXSEL, 32'h0000000F);
    run_cmd <= 1'b1;
    wait_out(1'b0, 3 * TC + 2);
    chk("no relay", 32'h0, 32'(aux_relay));
    run(1'b0);
    apb(1'b1, OFS_CTRL, 32'h00010002);
    for (int k = 0; k < 2; k++) begin
      run(1'b1);
      chk("damper relay", 32'h1, 32'(aux_relay));
      chk("early start", 32'h0, 32'(motor_start));
      wait_out(1'b0, 3 * SEC);
      chk("delay", 32'h1, 32'(n >= SEC - 4 * TC));
      chk("relay held", 32'h1, 32'(aux_relay));
      run(1'b0);
      chk("stop", 32'h0, 32'({aux_relay, motor_start}));
    end
    sw_asg <= 1'b1;
    run_cmd <= 1'b1;
    wait_out(1'b0, 2 * SEC);
    chk("switch start", 32'h1, 32'(n < SEC / 2));
    run(1'b0);
    stuck <= 1'b1;
    run_cmd <= 1'b1;
    wait_out(1'b1, 3 * SEC);
    cyc(2 * TC);
    chk("fault start", 32'h0, 32'({aux_relay, motor_start}));
    run(1'b0);
    chk("fault clear", 32'h0, 32'(damper_fault));
    sw_asg <= 1'b0;
    stuck <= 1'b0;
    apb(1'b1, OFS_CTRL, 32'h00020002);
    apb(1'b1, OFS_AUXSEL, 32'h00001110);
    run(1'b1);
    chk("lube on", 32'h3, 32'(aux_relay));
    wait_out(1'b0, 3 * SEC);
    cyc(3 * TC);
    chk("refill", 32'h2, 32'(aux_relay));
    cyc(2 * SEC + 8 * TC);
    chk("refill end", 32'h1, 32'({aux_relay, motor_start}));
    run(1'b0);
    finish_test();
  end
endmodule
